// ===== design/tcm_pkg.sv
// package: register map, fields and decoders of the mode block
package tcm_pkg;

    // register byte offsets
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] ENABLE_OFS = 8'h04;
    localparam logic [7:0] CMP3_OFS = 8'h08;
    localparam logic [7:0] CAP4_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // reset values
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic ENABLE_RESET = 1'b0;

    // enable register bit positions
    localparam int CH4_ENABLE_BIT = 12;
    localparam int CH3_ENABLE_BIT = 8;

    // status register bit positions
    localparam int STAT_LEVEL_BIT = 0;
    localparam int STAT_REF3_BIT = 1;
    localparam int STAT_PSC_LSB = 4;

    // filter base rates in MHz, crystal and rc
    localparam int PCLK_XTAL_MHZ = 12;
    localparam int PCLK_RC_MHZ = 6;

    // mode register, bit 15 first
    typedef struct packed {
        logic [3:0] ch4_input_filter;
        logic [1:0] ch4_capture_prescale;
        logic [1:0] ch4_direction_select;
        logic spare7;
        logic [2:0] ch3_compare_mode;
        logic ch3_compare_buffer_en;
        logic ch3_compare_fast_en;
        logic [1:0] ch3_direction_select;
    } tcm_mode_type;

    typedef enum logic [1:0] {
        DIR_OUTPUT = 2'b00,
        DIR_OWN_INPUT = 2'b01,
        DIR_NEIGHBOUR_INPUT = 2'b10,
        DIR_TRIGGER = 2'b11
    } tcm_dir_type;

    typedef enum logic [2:0] {
        OCM_FROZEN = 3'h0,
        OCM_SET_ON_MATCH = 3'h1,
        OCM_CLEAR_ON_MATCH = 3'h2,
        OCM_TOGGLE = 3'h3,
        OCM_FORCE_LOW = 3'h4,
        OCM_FORCE_HIGH = 3'h5,
        OCM_PWM1 = 3'h6,
        OCM_PWM2 = 3'h7
    } tcm_ocm_type;

    // filter setting: sample period 2**rate_shift, run length samples
    typedef struct packed {
        logic [2:0] rate_shift;
        logic [3:0] samples;
    } tcm_filter_type;

    function automatic tcm_filter_type tcm_filter_decode(input logic [3:0] code);
        tcm_filter_type f;
        f = '{rate_shift: 3'h0, samples: 4'h1};
        unique case (code)
            4'h0: f = '{rate_shift: 3'h0, samples: 4'h1};
            4'h1: f = '{rate_shift: 3'h0, samples: 4'h2};
            4'h2: f = '{rate_shift: 3'h0, samples: 4'h4};
            4'h3: f = '{rate_shift: 3'h1, samples: 4'h8};
            4'h4: f = '{rate_shift: 3'h1, samples: 4'h8};
            4'h5: f = '{rate_shift: 3'h1, samples: 4'h8};
            4'h6: f = '{rate_shift: 3'h2, samples: 4'h6};
            4'h7: f = '{rate_shift: 3'h2, samples: 4'h8};
            4'h8: f = '{rate_shift: 3'h3, samples: 4'h8};
            4'h9: f = '{rate_shift: 3'h3, samples: 4'h8};
            4'hA: f = '{rate_shift: 3'h4, samples: 4'h5};
            4'hB: f = '{rate_shift: 3'h4, samples: 4'h6};
            4'hC: f = '{rate_shift: 3'h5, samples: 4'h5};
            4'hD: f = '{rate_shift: 3'h5, samples: 4'h5};
            4'hE: f = '{rate_shift: 3'h5, samples: 4'h6};
            4'hF: f = '{rate_shift: 3'h5, samples: 4'h8};
        endcase
        return f;
    endfunction

endpackage

// ===== design/tcm_input_filter.sv
// digital input filter: decimated sampling and run-length check
`timescale 1ns/10ps
`default_nettype none
module tcm_input_filter
    import tcm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic [3:0] filter_code,
    input wire logic active,
    // level in and qualified level out
    input wire logic level_in,
    output logic level_out
);
    import tcm_pkg::*;

    tcm_filter_type setting;
    logic [4:0] div_q;
    logic [4:0] div_mask;
    logic sample_en;
    logic [3:0] run_q;
    logic level_q;

    assign setting = tcm_filter_decode(filter_code);
    // pclk stands for the peripheral base rate [RQ8]
    assign div_mask = 5'((6'h01 << setting.rate_shift) - 6'h01);
    assign sample_en = (div_q & div_mask) == 5'h00;
    assign level_out = level_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_q <= 5'h00;
        else
            div_q <= div_q + 5'h01;
    end

    // a new level needs samples equal samples in a row [RQ2]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= 4'h0;
            level_q <= 1'b0;
        end
        else if (!active)
        begin
            // no filtering as an output [RQ1]
            run_q <= 4'h0;
            level_q <= level_in;
        end
        else if (sample_en)
        begin
            if (level_in == level_q)
                run_q <= 4'h0;
            else if (run_q + 4'h1 >= setting.samples)
            begin
                level_q <= level_in;
                run_q <= 4'h0;
            end
            else
                run_q <= run_q + 4'h1;
        end
    end

endmodule
`default_nettype wire

// ===== design/tcm_compare_ref.sv
// output compare reference generator for one channel
`timescale 1ns/10ps
`default_nettype none
module tcm_compare_ref
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // configuration
    input wire logic active,
    input wire tcm_pkg::tcm_ocm_type mode,
    input wire logic fast_en,
    // counter side
    input wire logic [CNT_W-1:0] count,
    input wire logic count_down,
    input wire logic [CNT_W-1:0] compare,
    input wire logic trigger_edge,
    // reference out
    output logic ref_out
);
    import tcm_pkg::*;

    logic ref_q;
    logic match;
    logic below;
    logic pwm;
    logic fast_hit;

    assign match = count == compare;
    assign below = count < compare;
    assign pwm = (mode == OCM_PWM1) || (mode == OCM_PWM2);
    // in pwm modes a trigger edge acts as a match [RQ19]
    assign fast_hit = fast_en && pwm && trigger_edge; // [RQ16]
    assign ref_out = ref_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_q <= 1'b0;
        else if (!active)
            ref_q <= ref_q; // held unless the channel is an output [RQ14]
        else if (fast_hit)
            ref_q <= 1'b1;
        else
        begin
            unique case (mode) // [RQ17]
                OCM_FROZEN: ref_q <= ref_q;
                OCM_SET_ON_MATCH: ref_q <= match ? 1'b1 : ref_q;
                OCM_CLEAR_ON_MATCH: ref_q <= match ? 1'b0 : ref_q;
                OCM_TOGGLE: ref_q <= match ? ~ref_q : ref_q;
                OCM_FORCE_LOW: ref_q <= 1'b0;
                OCM_FORCE_HIGH: ref_q <= 1'b1;
                OCM_PWM1: ref_q <= count_down ? (count <= compare) : below;
                OCM_PWM2: ref_q <= count_down ? below : ~below;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== design/tcm_mode_ctrl.sv
// channel 3/4 capture-compare mode block
//
// Contract
// [RQ1] ch4 filter field is bits 15:12 and acts only when ch4 is an input.
// [RQ2] a new input level passes only after N consecutive equal samples.
// [RQ3] codes 0000/0001/0010: full clock, no filter, two and four samples.
// [RQ4] codes 0011 and 0100: half clock rate, eight samples.
// [RQ5] codes 0110 and 0111: quarter clock rate, six and eight samples.
// [RQ6] code 1000: eighth rate, eight; 1010/1011: sixteenth rate, five and six.
// [RQ7] codes 1100/1110/1111: thirty-second rate, five, six and eight samples.
// [RQ8] the filter base rate is the peripheral clock, 12 or 6 MHz.
// [RQ9] ch4 prescale bits 11:10 capture every 1, 2, 4 or 8 events.
// [RQ10] the prescaler acts only while ch4 is an input.
// [RQ11] ch4 direction bits 9:8: output, own input, or channel 3 input.
// [RQ12] direction 11 takes the internal trigger chosen by the slave mode setup.
// [RQ13] software changes ch4 direction only while the channel is disabled.
// [RQ14] ch3 compare mode bits 6:4 act only when ch3 direction is zero.
// [RQ15] bit 3 buffers the ch3 compare value when ch3 is an output.
// [RQ16] bit 2 is the ch3 fast enable, acting only for an output.
// [RQ17] compare modes: frozen, set, clear, toggle, force low/high, pwm 1, pwm 2.
// [RQ18] unbuffered writes hit the active compare; buffered ones load on update.
// [RQ19] fast enable in pwm modes makes a trigger edge act as a match.
// [RQ20] undocumented filter codes 0101, 1001, 1101 get defined settings.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module tcm_mode_ctrl
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins, asynchronous
    input wire logic timer_input_three,
    input wire logic timer_input_four,
    // counter side, same clock
    input wire logic internal_trigger_input,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic counter_down,
    input wire logic timer_update_event,
    // channel results
    output logic ch4_capture_strobe,
    output logic [CNT_W-1:0] ch4_capture_value,
    output logic ch3_output_reference
);
    import tcm_pkg::*;

    localparam int NPIN = 2;

    // register state
    logic [15:0] mode_q;
    tcm_mode_type mode;
    logic ch4_channel_enable_q;
    logic ch3_channel_enable_q;
    logic [CNT_W-1:0] cmp3_buffer_q;
    logic [CNT_W-1:0] cmp3_active_q;
    logic [CNT_W-1:0] cap4_q;
    logic cap_strobe_q;

    // bus decode
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic [31:0] rd_data;

    // input path
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_level;
    logic ch4_source;
    logic ch4_is_input;
    logic ch3_is_output;
    logic filt_level;
    logic filt_prev_q;
    logic in_edge;
    logic [2:0] psc_cnt_q;
    logic [2:0] psc_limit;
    logic trig_prev_q;
    logic trig_edge;
    logic ref3;

    assign mode = tcm_mode_type'(mode_q);
    // ch4 is an input for any nonzero direction code [RQ1]
    assign ch4_is_input = mode.ch4_direction_select != DIR_OUTPUT;
    assign ch3_is_output = mode.ch3_direction_select == DIR_OUTPUT;

    // apb: zero wait states, error on an unmapped offset
    assign pready = 1'b1;
    assign addr_hit = (paddr == MODE_OFS) || (paddr == ENABLE_OFS) || (paddr == CMP3_OFS) ||
        (paddr == CAP4_OFS) || (paddr == STATUS_OFS);
    assign pslverr = psel && penable && !addr_hit;
    assign wr_en = psel && penable && pwrite && addr_hit;
    assign rd_en = psel && !penable && !pwrite;

    // direction writes are not blocked: software keeps ch4 off [RQ13]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= MODE_RESET;
        else if (wr_en && paddr == MODE_OFS)
            mode_q <= pwdata[15:0]; // [RQ11] [RQ9] [RQ14] [RQ15] [RQ16]
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch4_channel_enable_q <= ENABLE_RESET;
            ch3_channel_enable_q <= ENABLE_RESET;
        end
        else if (wr_en && paddr == ENABLE_OFS)
        begin
            ch4_channel_enable_q <= pwdata[CH4_ENABLE_BIT];
            ch3_channel_enable_q <= pwdata[CH3_ENABLE_BIT];
        end
    end

    // compare value: direct, or from the buffer at update events [RQ18]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmp3_buffer_q <= CMP_RESET[CNT_W-1:0];
        else if (wr_en && paddr == CMP3_OFS)
            cmp3_buffer_q <= pwdata[CNT_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmp3_active_q <= CMP_RESET[CNT_W-1:0];
        else if (!(mode.ch3_compare_buffer_en && ch3_is_output))
        begin
            // unbuffered: writes land at once [RQ15]
            if (wr_en && paddr == CMP3_OFS)
                cmp3_active_q <= pwdata[CNT_W-1:0];
            else
                cmp3_active_q <= cmp3_buffer_q;
        end
        else if (timer_update_event)
            cmp3_active_q <= cmp3_buffer_q; // [RQ18]
    end

    // read mux, registered in setup so prdata comes from flops
    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (paddr)
            MODE_OFS: rd_data = {16'h0000, mode_q};
            ENABLE_OFS:
            begin
                rd_data[CH4_ENABLE_BIT] = ch4_channel_enable_q;
                rd_data[CH3_ENABLE_BIT] = ch3_channel_enable_q;
            end
            CMP3_OFS: rd_data[CNT_W-1:0] = cmp3_buffer_q;
            CAP4_OFS: rd_data[CNT_W-1:0] = cap4_q;
            STATUS_OFS:
            begin
                rd_data[STAT_LEVEL_BIT] = filt_level;
                rd_data[STAT_REF3_BIT] = ref3;
                rd_data[STAT_PSC_LSB +: 3] = psc_cnt_q;
            end
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= rd_data;
    end

    // three-stage pin sync; a change counts once stages two and three agree
    assign pin_raw = {timer_input_three, timer_input_four};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            logic [2:0] sync_q;
            logic agreed_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    sync_q <= 3'h0;
                else
                    sync_q <= {sync_q[1:0], pin_raw[gi]};
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    agreed_q <= 1'b0;
                else if (sync_q[1] == sync_q[2])
                    agreed_q <= sync_q[2];
            end
            assign pin_level[gi] = agreed_q;
        end
    endgenerate

    // ch4 source: pin_level[1] is pin three, pin_level[0] pin four
    always_comb
    begin
        unique case (tcm_dir_type'(mode.ch4_direction_select))
            DIR_OUTPUT: ch4_source = 1'b0;
            DIR_OWN_INPUT: ch4_source = pin_level[0]; // [RQ11]
            DIR_NEIGHBOUR_INPUT: ch4_source = pin_level[1]; // [RQ11]
            // trigger is on pclk already [RQ12]
            DIR_TRIGGER: ch4_source = internal_trigger_input;
        endcase
    end

    // filter table covers all sixteen codes [RQ3] [RQ4] [RQ5]
    tcm_input_filter u_filter (
        .pclk(pclk),
        .presetn(presetn),
        .filter_code(mode.ch4_input_filter), // [RQ6] [RQ7] [RQ20]
        .active(ch4_is_input),
        .level_in(ch4_source),
        .level_out(filt_level)
    );

    // rising edge of the qualified level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            filt_prev_q <= 1'b0;
        else
            filt_prev_q <= filt_level;
    end

    assign in_edge = filt_level && !filt_prev_q && ch4_is_input && ch4_channel_enable_q;

    // capture prescaler: events needed minus one
    always_comb
    begin
        unique case (mode.ch4_capture_prescale) // [RQ9]
            2'b00: psc_limit = 3'h0;
            2'b01: psc_limit = 3'h1;
            2'b10: psc_limit = 3'h3;
            2'b11: psc_limit = 3'h7;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            psc_cnt_q <= 3'h0;
        else if (!ch4_is_input || !ch4_channel_enable_q)
            psc_cnt_q <= 3'h0; // idle as an output [RQ10]
        else if (in_edge)
            psc_cnt_q <= (psc_cnt_q >= psc_limit) ? 3'h0 : psc_cnt_q + 3'h1;
    end

    // capture on the qualifying event
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap4_q <= '0;
            cap_strobe_q <= 1'b0;
        end
        else
        begin
            cap_strobe_q <= in_edge && psc_cnt_q >= psc_limit; // [RQ9]
            if (in_edge && psc_cnt_q >= psc_limit)
                cap4_q <= counter_value;
        end
    end

    assign ch4_capture_strobe = cap_strobe_q;
    assign ch4_capture_value = cap4_q;

    // trigger edge for the fast compare path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trig_prev_q <= 1'b0;
        else
            trig_prev_q <= internal_trigger_input;
    end

    assign trig_edge = internal_trigger_input && !trig_prev_q;

    // ch3 reference; one flop keeps the trigger path short
    tcm_compare_ref #(
        .CNT_W(CNT_W)
    ) u_cmp3 (
        .pclk(pclk),
        .presetn(presetn),
        .active(ch3_is_output), // [RQ14]
        .mode(tcm_ocm_type'(mode.ch3_compare_mode)),
        .fast_en(mode.ch3_compare_fast_en && ch3_is_output), // [RQ16] [RQ19]
        .count(counter_value),
        .count_down(counter_down),
        .compare(cmp3_active_q),
        .trigger_edge(trig_edge),
        .ref_out(ref3)
    );

    assign ch3_output_reference = ref3;

endmodule
`default_nettype wire

// ===== tb/tcm_pin_model.sv
// pin and trigger model for the ch3/4 mode block
`timescale 1ns/10ps
`default_nettype none
module tcm_pin_model (
    // clock
    input wire logic pclk,
    // pins and trigger, driven low while idle
    output logic timer_input_three,
    output logic timer_input_four,
    output logic internal_trigger_input
);
    logic [2:0] line_q = 3'h0;
    assign timer_input_three = line_q[0];
    assign timer_input_four = line_q[1];
    // line 2 models the routed trigger
    assign internal_trigger_input = line_q[2];
    // hi cycles high then lo cycles low
    task automatic burst(input int line, input int count, input int hi, input int lo);
        for (int i = 0; i < count; i++)
        begin
            line_q[line] <= 1'b1;
            repeat (hi) @(posedge pclk);
            line_q[line] <= 1'b0;
            repeat (lo) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/tcm_mode_ctrl_asserts.sv
// port checker for the ch3/4 mode block
`timescale 1ns/10ps
`default_nettype none
module tcm_mode_ctrl_asserts
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // trigger and counter
    input wire logic internal_trigger_input,
    input wire logic [CNT_W-1:0] counter_value,
    // results
    input wire logic ch4_capture_strobe,
    input wire logic [CNT_W-1:0] ch4_capture_value,
    input wire logic ch3_output_reference
);
    import tcm_pkg::*;
    // shadow of mode and ch4 enable
    logic [15:0] mode_q;
    logic en4_q;
    logic mapped, live3, force_hi, force_lo, fast_arm;
    assign mapped = paddr inside {MODE_OFS, ENABLE_OFS, CMP3_OFS, CAP4_OFS, STATUS_OFS};
    assign live3 = mode_q[1:0] == 2'b00;
    assign force_hi = live3 && mode_q[6:4] == 3'h5;
    assign force_lo = live3 && mode_q[6:4] == 3'h4;
    assign fast_arm = live3 && mode_q[6:5] == 2'b11 && mode_q[2];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= 16'h0000;
            en4_q <= 1'b0;
        end
        else if (psel && penable && pwrite && pready)
        begin
            if (paddr == MODE_OFS)
                mode_q <= pwdata[15:0];
            if (paddr == ENABLE_OFS)
                en4_q <= pwdata[CH4_ENABLE_BIT];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    slverr_decode_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("bad pslverr");
    unmapped_zero_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read data");
    mode_readback_a: assert property (psel && penable && !pwrite && paddr == MODE_OFS
        |-> prdata == {16'h0000, mode_q}) else $error("mode readback");
    capture_value_a: assert property (ch4_capture_strobe
        |-> ch4_capture_value == $past(counter_value)) else $error("capture value");
    capture_gate_a: assert property (ch4_capture_strobe |-> mode_q[9:8] != 2'b00 && en4_q)
        else $error("capture gated off");
    force_high_a: assert property (force_hi [*2] |-> ch3_output_reference)
        else $error("forced high is low");
    force_low_a: assert property (force_lo [*2] |-> !ch3_output_reference)
        else $error("forced low is high");
    hold_inactive_a: assert property (!live3 && !$past(live3)
        |-> $stable(ch3_output_reference)) else $error("ref moved as input");
    fast_hit_a: assert property (fast_arm && $rose(internal_trigger_input)
        |-> ##[1:3] ch3_output_reference) else $error("fast trigger missed");
    cover property (ch4_capture_strobe);
    cover property (fast_arm && $rose(internal_trigger_input));
    cover property (psel && penable && pslverr);
endmodule
bind tcm_mode_ctrl tcm_mode_ctrl_asserts #(.CNT_W(CNT_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_trigger_input(internal_trigger_input), .counter_value(counter_value),
    .ch4_capture_strobe(ch4_capture_strobe), .ch4_capture_value(ch4_capture_value),
    .ch3_output_reference(ch3_output_reference));
`default_nettype wire

// ===== tb/tb.sv
// bench for the ch3/4 mode block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tcm_pkg::*;
    typedef struct {int dir; int psc; int line; int exp;} tcm_row_type;
    // dir, prescale, line (0 pin three, 1 pin four, 2 trigger), strobes
    tcm_row_type rows[9] = '{'{1, 0, 1, 8}, '{1, 1, 1, 4}, '{1, 2, 1, 2}, '{1, 3, 1, 1},
        '{0, 0, 1, 0}, '{2, 0, 0, 8}, '{2, 0, 1, 0}, '{3, 0, 2, 8}, '{1, 0, 0, 0}};
    int fs[16] = '{0, 0, 0, 1, 1, 1, 2, 2, 3, 3, 4, 4, 5, 5, 5, 5};
    int fn[16] = '{1, 2, 4, 8, 8, 8, 6, 8, 8, 8, 5, 6, 5, 5, 6, 8};
    logic [7:0] ra[5] = '{MODE_OFS, ENABLE_OFS, CMP3_OFS, CAP4_OFS, 8'h14};
    logic [31:0] rx[5] = '{32'h0000FFFF, 32'h00001100, 32'h0000FFFF, 32'h0, 32'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cnt_run;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic timer_input_three, timer_input_four, internal_trigger_input;
    logic counter_down, timer_update_event, ch4_capture_strobe, ch3_output_reference;
    logic [15:0] counter_value, ch4_capture_value;
    int num_errors = 0, samples_checked = 0, strobes = 0, ref_hi = 0;
    tcm_mode_ctrl #(.CNT_W(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_input_three(timer_input_three),
        .timer_input_four(timer_input_four), .internal_trigger_input(internal_trigger_input),
        .counter_value(counter_value), .counter_down(counter_down),
        .timer_update_event(timer_update_event), .ch4_capture_strobe(ch4_capture_strobe),
        .ch4_capture_value(ch4_capture_value), .ch3_output_reference(ch3_output_reference));
    tcm_pin_model pins (.pclk(pclk), .timer_input_three(timer_input_three),
        .timer_input_four(timer_input_four), .internal_trigger_input(internal_trigger_input));
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (cnt_run)
            counter_value <= counter_value + 16'h0001;
        if (ch4_capture_strobe === 1'b1)
            strobes++;
        if (ch3_output_reference === 1'b1)
            ref_hi++;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // entered after a rising edge; ends with an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check(32'(e), 32'(exp_err));
    endtask
    task automatic cfg(input logic [31:0] mode);
        wr(ENABLE_OFS, 32'h0);
        wr(MODE_OFS, mode);
        wr(ENABLE_OFS, 32'h1000);
    endtask
    task automatic ref_chk(input logic [31:0] mode, input logic e);
        wr(MODE_OFS, mode);
        repeat (3) @(posedge pclk);
        check(32'(ch3_output_reference), 32'(e));
    endtask
    initial
    begin
        repeat (50000) @(posedge pclk);
        num_errors++;
        report_and_stop();
    end
    initial
    begin
        int n, lo, hi, r;
        {presetn, psel, penable, pwrite, timer_update_event, counter_down} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        counter_value = 16'h0000;
        cnt_run = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++)
        begin
            rd_chk(ra[i], 32'h0, i == 4);
            wr(ra[i], 32'hFFFFFFFF);
            rd_chk(ra[i], rx[i], i == 4);
        end
        foreach (rows[i])
        begin
            cfg(32'(rows[i].psc * 1024 + rows[i].dir * 256));
            n = strobes;
            pins.burst(rows[i].line, 8, 4, 4);
            repeat (12) @(posedge pclk);
            check(32'(strobes - n), 32'(rows[i].exp));
        end
        for (int c = 0; c < 16; c++)
        begin
            lo = 4 + (fn[c] - 1) * (1 << fs[c]);
            hi = 6 + (fn[c] + 1) * (1 << fs[c]);
            cfg(32'(c * 4096 + 256));
            fork
                pins.burst(1, 1, hi + 4, hi + 4);
            join_none
            n = 0;
            @(negedge pclk);
            while (ch4_capture_strobe !== 1'b1 && n < hi + 2)
            begin
                n++;
                @(negedge pclk);
            end
            check(32'(n), 32'(n < lo ? lo : (n > hi ? hi : n)));
            wait fork;
        end
        n = strobes;
        pins.burst(1, 1, 100, 300);
        check(32'(strobes - n), 32'h0);
        cnt_run <= 1'b0;
        wr(ENABLE_OFS, 32'h0);
        counter_value <= 16'h0005;
        wr(MODE_OFS, 32'h0);
        wr(ENABLE_OFS, 32'h100);
        for (int m = 4; m < 8; m++)
            for (int k = 0; k < 2; k++)
            begin
                wr(CMP3_OFS, k ? 32'h3 : 32'h9);
                ref_chk(32'(m * 16), (m == 5) || (m > 5 && ((k == 0) != (m == 7))));
            end
        ref_chk(32'h68, 1'b0);
        wr(CMP3_OFS, 32'h9);
        ref_chk(32'h68, 1'b0);
        timer_update_event <= 1'b1;
        @(posedge pclk);
        timer_update_event <= 1'b0;
        repeat (3) @(posedge pclk);
        check(32'(ch3_output_reference), 32'h1);
        ref_chk(32'h40, 1'b0);
        wr(CMP3_OFS, 32'h5);
        ref_chk(32'h10, 1'b1);
        ref_chk(32'h20, 1'b0);
        ref_chk(32'h50, 1'b1);
        ref_chk(32'h41, 1'b1);
        wr(CMP3_OFS, 32'h3);
        ref_chk(32'h60, 1'b0);
        r = ref_hi;
        pins.burst(2, 1, 4, 4);
        check(32'(ref_hi - r), 32'h0);
        ref_chk(32'h64, 1'b0);
        r = ref_hi;
        pins.burst(2, 1, 4, 4);
        check(32'(ref_hi > r), 32'h1);
        counter_down <= 1'b1;
        wr(CMP3_OFS, 32'h5);
        ref_chk(32'h60, 1'b1);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(MODE_OFS, 32'h0, 1'b0);
        check(32'(ch3_output_reference), 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
